//--- verilog/cfi_pkg.sv
// Package for the codec fault interrupt unit: register map, field layout,
// reset values, pin drive modes and the fault event carrier.
// Assumes all users import the whole package.
package cfi_pkg;

   // Register offsets on the control port
   localparam logic [7:0] CFI_ADDR_ADC_PWRDN  = 8'h10;
   localparam logic [7:0] CFI_ADDR_DAC_PWRDN  = 8'h15;
   localparam logic [7:0] CFI_ADDR_IRQ_CTRL   = 8'h1E;
   localparam logic [7:0] CFI_ADDR_MASK_FAULT = 8'h1F;
   localparam logic [7:0] CFI_ADDR_MASK_DAC   = 8'h20;
   localparam logic [7:0] CFI_ADDR_FLAG_FAULT = 8'h21;
   localparam logic [7:0] CFI_ADDR_FLAG_DAC   = 8'h22;

   // Channel counts
   localparam int CFI_NUM_ADC = 4;
   localparam int CFI_NUM_DAC = 5;

   // Control register fields
   localparam int CFI_CTRL_AUTOSET_BIT = 7;
   localparam int CFI_CTRL_DRIVE_HI    = 6;
   localparam int CFI_CTRL_DRIVE_LO    = 5;
   localparam logic [7:0] CFI_CTRL_USED = 8'hE0;

   // Fault flag and mask layout (bit 4 reserved)
   localparam int CFI_BIT_TESTMODE = 7;
   localparam int CFI_BIT_SERIAL   = 6;
   localparam int CFI_BIT_CLOCKING = 5;
   localparam logic [7:0] CFI_FAULT_USED = 8'hEF;
   localparam logic [7:0] CFI_ZERO_BYTE  = 8'h00;

   // Reset values
   localparam logic [7:0] CFI_RST_CTRL       = 8'h00;
   localparam logic [7:0] CFI_RST_MASK_FAULT = 8'h00;
   localparam logic [4:0] CFI_RST_MASK_DAC   = 5'h00;
   localparam logic [3:0] CFI_RST_ADC_PWRDN  = 4'hF;
   localparam logic [4:0] CFI_RST_DAC_PWRDN  = 5'h1F;

   typedef enum logic [1:0] {
      CFI_DRIVE_ACT_HIGH = 2'h0,
      CFI_DRIVE_ACT_LOW  = 2'h1,
      CFI_DRIVE_OPEN_LOW = 2'h2,
      CFI_DRIVE_RESERVED = 2'h3
   } cfi_drive_t;

   // One-cycle fault event pulses from the datapaths
   typedef struct packed {
      logic       testmode_entry;
      logic       clk_ratio_change;
      logic       clocking_fault;
      logic [3:0] adc_overflow;
      logic [4:0] dac_clipping;
   } cfi_events_t;

endpackage : cfi_pkg

//--- verilog/cfi_sticky_bank.sv
// Bank of sticky fault flags, cleared by a read strobe.
// Assumes set and clear come from logic on clk_sys.
`timescale 1ns/1ps
module cfi_sticky_bank #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] set_evt,
   input  wire logic         clr_rd,
   output logic      [W-1:0] flags_ff
);
   logic [W-1:0] nxt_flags;

   always_comb begin
      // Set wins over the read clear: no event is lost
      if (clr_rd) begin
         nxt_flags = set_evt;
      end else begin
         nxt_flags = flags_ff | set_evt;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end
endmodule : cfi_sticky_bank

//--- verilog/cfi_irq_unit.sv
// Codec fault interrupt unit: sticky fault flags, masks, power-down bits
// and the configurable interrupt pin.
// Assumes the control-port engine gives one-cycle read/write strobes on
// clk_sys and fault events arrive as clk_sys pulses.
`timescale 1ns/1ps
// Functional notes
// - Mode 0: reading fault sets its mask
// - Mode 1: reads leave masks unchanged
// - Drive field: 00 high, 01 low, 10 open-drain
// - Masked faults never flag the pin
// - Record fault on unintended test-mode entry
// - Format or speed change while running: fault
// - Full power-down means all power-down bits set
// - Clock ratio change while running: two faults
// - Flags sticky until cleared
// - First flag register bit layout
// - First mask register mirrors flag layout
// - Second mask holds DAC clipping masks
// - Control: autoset bit 7, drive 6:5
// - DAC power-down bit per channel
// - Second flag register holds DAC clipping
// - ADC power-down bit per channel
module cfi_irq_unit
   import cfi_pkg::*;
#(
   parameter int NUM_ADC = CFI_NUM_ADC,
   parameter int NUM_DAC = CFI_NUM_DAC
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata_ff,
   input  wire cfi_events_t       evt,
   input  wire logic [1:0]        serial_format_select,
   input  wire logic [1:0]        speed_mode_select,
   output logic      [NUM_ADC-1:0] adc_path_powerdown_ff,
   output logic      [NUM_DAC-1:0] dac_path_powerdown_ff,
   output logic                   irq_pin_o_ff,
   output logic                   irq_pin_oe_ff
);
   logic [7:0]         ctrl_ff;
   logic [7:0]         mask1_ff;
   logic [NUM_DAC-1:0] mask2_ff;
   logic [1:0]         fmt_prev_ff;
   logic [1:0]         speed_prev_ff;
   logic [7:0]         flags1;
   logic [NUM_DAC-1:0] flags2;

   logic [7:0]         nxt_ctrl;
   logic [7:0]         nxt_mask1;
   logic [NUM_DAC-1:0] nxt_mask2;
   logic [NUM_ADC-1:0] nxt_adc_pwrdn;
   logic [NUM_DAC-1:0] nxt_dac_pwrdn;
   logic [7:0]         nxt_rdata;
   logic               nxt_pin_o;
   logic               nxt_pin_oe;

   logic wr_ctrl, wr_mask1, wr_mask2, wr_adc, wr_dac;
   logic rd_flag1, rd_flag2;
   logic full_pwrdn, cfg_changed, serial_set, clocking_set, pend;
   logic [7:0] set1;
   cfi_drive_t drive_sel;

   assign wr_ctrl  = reg_wr && (reg_addr == CFI_ADDR_IRQ_CTRL);
   assign wr_mask1 = reg_wr && (reg_addr == CFI_ADDR_MASK_FAULT);
   assign wr_mask2 = reg_wr && (reg_addr == CFI_ADDR_MASK_DAC);
   assign wr_adc   = reg_wr && (reg_addr == CFI_ADDR_ADC_PWRDN);
   assign wr_dac   = reg_wr && (reg_addr == CFI_ADDR_DAC_PWRDN);
   assign rd_flag1 = reg_rd && (reg_addr == CFI_ADDR_FLAG_FAULT);
   assign rd_flag2 = reg_rd && (reg_addr == CFI_ADDR_FLAG_DAC);

   assign drive_sel = cfi_drive_t'(ctrl_ff[CFI_CTRL_DRIVE_HI:CFI_CTRL_DRIVE_LO]);

   // Fault detection
   assign full_pwrdn = (&adc_path_powerdown_ff)
                     && (&dac_path_powerdown_ff);
   assign cfg_changed = (serial_format_select != fmt_prev_ff)
                     || (speed_mode_select != speed_prev_ff);
   assign serial_set = !full_pwrdn
                     && (cfg_changed || evt.clk_ratio_change);
   assign clocking_set = evt.clocking_fault
                     || (!full_pwrdn && evt.clk_ratio_change);

   always_comb begin
      set1 = '0;
      set1[CFI_BIT_TESTMODE] = evt.testmode_entry;
      set1[CFI_BIT_SERIAL]   = serial_set;
      set1[CFI_BIT_CLOCKING] = clocking_set;
      set1[NUM_ADC-1:0]      = evt.adc_overflow;
   end

   cfi_sticky_bank #(.W(8)) u_flags_fault (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_evt  (set1),
      .clr_rd   (rd_flag1),
      .flags_ff (flags1)
   );

   cfi_sticky_bank #(.W(NUM_DAC)) u_flags_dac (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_evt  (evt.dac_clipping),
      .clr_rd   (rd_flag2),
      .flags_ff (flags2)
   );

   // Pending uses current masks; a mask write takes effect on the next pin
   assign pend = (|(flags1 & ~mask1_ff)) || (|(flags2 & ~mask2_ff));

   always_comb begin
      nxt_ctrl      = ctrl_ff;
      nxt_mask1     = mask1_ff;
      nxt_mask2     = mask2_ff;
      nxt_adc_pwrdn = adc_path_powerdown_ff;
      nxt_dac_pwrdn = dac_path_powerdown_ff;
      if (wr_ctrl) begin
         nxt_ctrl = reg_wdata & CFI_CTRL_USED;
      end
      if (wr_mask1) begin
         nxt_mask1 = reg_wdata & CFI_FAULT_USED;
      end
      if (wr_mask2) begin
         nxt_mask2 = reg_wdata[NUM_DAC-1:0];
      end
      if (wr_adc) begin
         nxt_adc_pwrdn = reg_wdata[NUM_ADC-1:0];
      end
      if (wr_dac) begin
         nxt_dac_pwrdn = reg_wdata[NUM_DAC-1:0];
      end
      // Autoset masks exactly the faults the read reported
      if (!ctrl_ff[CFI_CTRL_AUTOSET_BIT]) begin
         if (rd_flag1) begin
            nxt_mask1 = nxt_mask1 | flags1;
         end
         if (rd_flag2) begin
            nxt_mask2 = nxt_mask2 | flags2;
         end
      end
   end

   always_comb begin
      nxt_rdata = CFI_ZERO_BYTE;
      unique case (reg_addr)
         CFI_ADDR_IRQ_CTRL:   nxt_rdata = ctrl_ff;
         CFI_ADDR_MASK_FAULT: nxt_rdata = mask1_ff;
         CFI_ADDR_MASK_DAC:   nxt_rdata[NUM_DAC-1:0] = mask2_ff;
         CFI_ADDR_FLAG_FAULT: nxt_rdata = flags1;
         CFI_ADDR_FLAG_DAC:   nxt_rdata[NUM_DAC-1:0] = flags2;
         CFI_ADDR_ADC_PWRDN:  nxt_rdata[NUM_ADC-1:0] = adc_path_powerdown_ff;
         CFI_ADDR_DAC_PWRDN:  nxt_rdata[NUM_DAC-1:0] = dac_path_powerdown_ff;
         default:             nxt_rdata = CFI_ZERO_BYTE;
      endcase
      if (!reg_rd) begin
         nxt_rdata = reg_rdata_ff;
      end
   end

   always_comb begin
      unique case (drive_sel)
         CFI_DRIVE_ACT_HIGH: begin
            nxt_pin_o  = pend;
            nxt_pin_oe = 1'b1;
         end
         CFI_DRIVE_ACT_LOW: begin
            nxt_pin_o  = !pend;
            nxt_pin_oe = 1'b1;
         end
         CFI_DRIVE_OPEN_LOW: begin
            nxt_pin_o  = 1'b0;
            nxt_pin_oe = pend;
         end
         // Reserved code: release the pin rather than guess a polarity
         CFI_DRIVE_RESERVED: begin
            nxt_pin_o  = 1'b0;
            nxt_pin_oe = 1'b0;
         end
      endcase
   end

   // Power-down reset state keeps a config change at start-up silent
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_ff               <= CFI_RST_CTRL;
         mask1_ff              <= CFI_RST_MASK_FAULT;
         mask2_ff              <= CFI_RST_MASK_DAC;
         adc_path_powerdown_ff <= CFI_RST_ADC_PWRDN;
         dac_path_powerdown_ff <= CFI_RST_DAC_PWRDN;
         fmt_prev_ff           <= '0;
         speed_prev_ff         <= '0;
         reg_rdata_ff          <= CFI_ZERO_BYTE;
         irq_pin_o_ff          <= 1'b0;
         irq_pin_oe_ff         <= 1'b0;
      end else begin
         ctrl_ff               <= nxt_ctrl;
         mask1_ff              <= nxt_mask1;
         mask2_ff              <= nxt_mask2;
         adc_path_powerdown_ff <= nxt_adc_pwrdn;
         dac_path_powerdown_ff <= nxt_dac_pwrdn;
         fmt_prev_ff           <= serial_format_select;
         speed_prev_ff         <= speed_mode_select;
         reg_rdata_ff          <= nxt_rdata;
         irq_pin_o_ff          <= nxt_pin_o;
         irq_pin_oe_ff         <= nxt_pin_oe;
      end
   end

   property p_autoset;
      @(posedge clk_sys) disable iff (rst)
      (rd_flag1 && !ctrl_ff[CFI_CTRL_AUTOSET_BIT])
         |=> ((mask1_ff & $past(flags1)) == $past(flags1));
   endproperty
   a_autoset: assert property (p_autoset)
      else $error("Autoset mode did not mask the read faults");

   property p_no_autoset;
      @(posedge clk_sys) disable iff (rst)
      (rd_flag1 && ctrl_ff[CFI_CTRL_AUTOSET_BIT] && !reg_wr)
         |=> $stable(mask1_ff);
   endproperty
   a_no_autoset: assert property (p_no_autoset)
      else $error("Mask changed on a read with autoset off");

   property p_open_drain;
      @(posedge clk_sys) disable iff (rst)
      (drive_sel == CFI_DRIVE_OPEN_LOW)
         |=> (!irq_pin_o_ff && (irq_pin_oe_ff == $past(pend)));
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("Open-drain pin drove high or wrong enable");

   property p_active_low_masked;
      @(posedge clk_sys) disable iff (rst)
      (drive_sel == CFI_DRIVE_ACT_LOW && (flags1 & ~mask1_ff) == '0
         && (flags2 & ~mask2_ff) == '0)
         |=> (irq_pin_o_ff && irq_pin_oe_ff);
   endproperty
   a_active_low_masked: assert property (p_active_low_masked)
      else $error("Masked faults flagged the active-low pin");

   property p_active_high;
      @(posedge clk_sys) disable iff (rst)
      (drive_sel == CFI_DRIVE_ACT_HIGH)
         |=> (irq_pin_oe_ff && (irq_pin_o_ff == $past(pend)));
   endproperty
   a_active_high: assert property (p_active_high)
      else $error("Active-high pin does not follow pending faults");

   property p_testmode;
      @(posedge clk_sys) disable iff (rst)
      evt.testmode_entry |=> flags1[CFI_BIT_TESTMODE];
   endproperty
   a_testmode: assert property (p_testmode)
      else $error("Test-mode entry not recorded");

   property p_cfg_change;
      @(posedge clk_sys) disable iff (rst)
      (cfg_changed && !full_pwrdn) |=> flags1[CFI_BIT_SERIAL];
   endproperty
   a_cfg_change: assert property (p_cfg_change)
      else $error("Serial config change while running not recorded");

   property p_ratio;
      @(posedge clk_sys) disable iff (rst)
      (evt.clk_ratio_change && !full_pwrdn)
         |=> (flags1[CFI_BIT_SERIAL] && flags1[CFI_BIT_CLOCKING]);
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("Clock ratio change did not record both faults");

   property p_quiet_pwrdn;
      @(posedge clk_sys) disable iff (rst)
      (full_pwrdn && !evt.clk_ratio_change && flags1 == '0 && !rd_flag1)
         |=> !flags1[CFI_BIT_SERIAL];
   endproperty
   a_quiet_pwrdn: assert property (p_quiet_pwrdn)
      else $error("Serial fault raised during full power-down");

   property p_sticky;
      @(posedge clk_sys) disable iff (rst)
      (flags1 != '0 && !rd_flag1) |=> ((flags1 & $past(flags1)) == $past(flags1));
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Fault flag dropped without a read");

   property p_read_clear;
      @(posedge clk_sys) disable iff (rst)
      rd_flag1 |=> ((reg_rdata_ff == $past(flags1)) && (flags1 == $past(set1)));
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("Flag read did not return and clear");

   property p_dac_pwrdn;
      @(posedge clk_sys) disable iff (rst)
      wr_dac |=> (dac_path_powerdown_ff == $past(reg_wdata[NUM_DAC-1:0]));
   endproperty
   a_dac_pwrdn: assert property (p_dac_pwrdn)
      else $error("DAC power-down write not taken");

endmodule : cfi_irq_unit

//--- testbench/cfi_host_model.sv
// Host microcontroller model: byte writes and reads on the control port.
// Assumes one-cycle strobes and read data one edge after the read strobe.
`timescale 1ns/1ps
module cfi_host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata_ff,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // Released lines show inverted values, never the last ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // One pulse is one read; a flag read clears
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata_ff;
   endtask : rd
endmodule : cfi_host_model

//--- testbench/cfi_irq_unit_tb.sv
// Self-checking bench for the codec fault interrupt unit.
// Assumes the host model drives the register strobes, the bench the rest.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module cfi_irq_unit_tb
   import cfi_pkg::*;
();
   logic        clk_sys;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata_ff;
   cfi_events_t evt;
   logic [1:0]  serial_format_select;
   logic [1:0]  speed_mode_select;
   logic [3:0]  adc_pd;
   logic [4:0]  dac_pd;
   logic        irq_pin_o_ff;
   logic        irq_pin_oe_ff;
   logic [7:0]  rd_val;
   int          err_count;
   int          n_checks;

   cfi_irq_unit DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff), .evt(evt),
      .serial_format_select(serial_format_select),
      .speed_mode_select(speed_mode_select),
      .adc_path_powerdown_ff(adc_pd), .dac_path_powerdown_ff(dac_pd),
      .irq_pin_o_ff(irq_pin_o_ff), .irq_pin_oe_ff(irq_pin_oe_ff));

   cfi_host_model host (.clk_sys(clk_sys), .reg_rdata_ff(reg_rdata_ff),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));

   always #4 clk_sys = ~clk_sys;

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rd_val);
      `CHK(rd_val, e)
   endtask : rdchk

   // Pin follows flags two edges after the cause
   task automatic pinchk(input logic [1:0] e);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK({irq_pin_o_ff, irq_pin_oe_ff}, e)
   endtask : pinchk

   task automatic pulse(input cfi_events_t v);
      @(posedge clk_sys);
      evt <= v;
      @(posedge clk_sys);
      evt <= '0;
   endtask : pulse

   task automatic t_reset;
      rdchk(CFI_ADDR_IRQ_CTRL, 8'h00);
      rdchk(CFI_ADDR_MASK_FAULT, 8'h00);
      rdchk(CFI_ADDR_MASK_DAC, 8'h00);
      rdchk(CFI_ADDR_ADC_PWRDN, 8'h0F);
      rdchk(CFI_ADDR_DAC_PWRDN, 8'h1F);
      rdchk(8'h30, 8'h00);
      host.wr(CFI_ADDR_FLAG_FAULT, 8'hFF);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h00);
      pinchk(2'b01);
   endtask : t_reset

   task automatic t_sticky;
      pulse('{testmode_entry: 1'b1, adc_overflow: 4'h1, default: '0});
      repeat (6) @(posedge clk_sys);
      pinchk(2'b11);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h81);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h00);
      rdchk(CFI_ADDR_MASK_FAULT, 8'h81);
      pulse('{testmode_entry: 1'b1, default: '0});
      pinchk(2'b01);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h80);
      host.wr(CFI_ADDR_MASK_FAULT, 8'hFF);
      rdchk(CFI_ADDR_MASK_FAULT, 8'hEF);
      host.wr(CFI_ADDR_MASK_FAULT, 8'h00);
   endtask : t_sticky

   task automatic t_mode1;
      host.wr(CFI_ADDR_IRQ_CTRL, 8'hFF);
      rdchk(CFI_ADDR_IRQ_CTRL, 8'hE0);
      host.wr(CFI_ADDR_IRQ_CTRL, 8'h80);
      pulse('{dac_clipping: 5'h10, default: '0});
      pinchk(2'b11);
      rdchk(CFI_ADDR_FLAG_DAC, 8'h10);
      rdchk(CFI_ADDR_MASK_DAC, 8'h00);
      host.wr(CFI_ADDR_MASK_DAC, 8'hFF);
      rdchk(CFI_ADDR_MASK_DAC, 8'h1F);
      pulse('{dac_clipping: 5'h1F, default: '0});
      pinchk(2'b01);
      rdchk(CFI_ADDR_FLAG_DAC, 8'h1F);
      host.wr(CFI_ADDR_MASK_DAC, 8'h00);
   endtask : t_mode1

   // First format change under full power-down, later changes while running
   task automatic t_serial;
      serial_format_select <= 2'h1;
      pulse('{clk_ratio_change: 1'b1, default: '0});
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h00);
      host.wr(CFI_ADDR_DAC_PWRDN, 8'hFE);
      rdchk(CFI_ADDR_DAC_PWRDN, 8'h1E);
      `CHK(dac_pd, 5'h1E)
      @(posedge clk_sys);
      speed_mode_select <= 2'h2;
      repeat (3) @(posedge clk_sys);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h40);
      pulse('{clk_ratio_change: 1'b1, default: '0});
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h60);
      host.wr(CFI_ADDR_DAC_PWRDN, 8'h1F);
      host.wr(CFI_ADDR_ADC_PWRDN, 8'h07);
      // Let the write settle before looking at the registered output
      #1;
      `CHK(adc_pd, 4'h7)
      @(posedge clk_sys);
      serial_format_select <= 2'h2;
      repeat (3) @(posedge clk_sys);
      rdchk(CFI_ADDR_FLAG_FAULT, 8'h40);
      host.wr(CFI_ADDR_ADC_PWRDN, 8'h0F);
   endtask : t_serial

   // Autoset off so every drive code sees a fresh pending flag
   task automatic t_pin;
      logic [1:0] idle [4];
      logic [1:0] act [4];
      idle = '{2'b01, 2'b11, 2'b00, 2'b00};
      act  = '{2'b11, 2'b01, 2'b01, 2'b00};
      for (int c = 0; c < 4; c++) begin
         host.wr(CFI_ADDR_IRQ_CTRL, {1'b1, 2'(c), 5'h00});
         pinchk(idle[c]);
         pulse('{clocking_fault: 1'b1, default: '0});
         pinchk(act[c]);
         rdchk(CFI_ADDR_FLAG_FAULT, 8'h20);
      end
   endtask : t_pin

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      clk_sys              = 1'b0;
      rst                  = 1'b1;
      evt                  = '0;
      serial_format_select = 2'h0;
      speed_mode_select    = 2'h0;
      err_count            = 0;
      n_checks             = 0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_sticky();
      t_mode1();
      t_serial();
      t_pin();
      summarize();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      err_count++;
      summarize();
   end
endmodule : cfi_irq_unit_tb
